// File: logic/sipo_pkg.sv
// sipo_pkg: constants shared by the serial-in parallel-out latch block.
// assumes a single system clock; all pin inputs are synchronised before use.
package sipo_pkg;
	localparam int unsigned SIPO_WIDTH     = 8;     // shift and storage stages
	localparam int unsigned SIPO_SYNC_BITS = 5;     // pin inputs passed through the synchroniser
	// positions of each pin in the synchroniser bundle
	localparam int unsigned SIPO_IDX_DATA  = 0;
	localparam int unsigned SIPO_IDX_SHCLK = 1;
	localparam int unsigned SIPO_IDX_STCLK = 2;
	localparam int unsigned SIPO_IDX_SHCLR = 3;
	localparam int unsigned SIPO_IDX_STCLR = 4;
	// synchroniser reset: clocks idle high so a pin held high at release is no edge,
	// clears read active so nothing moves until the pins have been seen
	localparam logic [SIPO_SYNC_BITS-1:0] SIPO_SYNC_RESET = 5'h06;
	localparam logic [SIPO_WIDTH-1:0]     SIPO_REG_RESET  = 8'h00;
	// clock edges from a pin edge to the register update: two sync, one register
	localparam int unsigned SIPO_LATENCY   = 3;
endpackage

// File: logic/sipo_sync.sv
// sipo_sync: two flip-flop synchroniser for a bundle of asynchronous pin levels.
// assumes each bit is an independent level; the first stage feeds only the second.
`timescale 1ns/1ps
module sipo_sync #(
	parameter int unsigned                 WIDTH     = 1,
	parameter logic [WIDTH-1:0]            RESET_VAL = '0
) (
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync;

	// both stages simply follow; no logic between them
	always_comb begin
		next_meta = async_i;
		next_sync = meta;
	end

	// constant reset values only
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta   <= RESET_VAL;
			sync_o <= RESET_VAL;
		end else begin
			meta   <= next_meta;
			sync_o <= next_sync;
		end
	end
endmodule

// File: logic/sipo_top.sv
// sipo_top: eight-stage serial shift register with an eight-bit storage register.
// assumes the controller's pins are asynchronous to clk_i and much slower than it.
// What this block does
// - Eight serial shift stages feed an eight-bit storage register that drives the outputs.
// - The shift register moves one place only on a rising shift clock while its clear is high.
// - Each shift loads serial input into stage 0; the chain output then shows old stage 6.
// - A store clock rise with both clears high copies all stages out without changing them.
// - When both clocks rise together the storage register takes the pre-shift contents.
// - A low shift clear holds all stages and the chain output low, storage untouched.
// - A low storage clear holds the storage register and outputs low, shift untouched.
// - A store clock rise while only the shift clear is low loads zeros into storage.
// - The last shift stage is brought out so that devices can be chained.
// - Each register has its own clock and its own active-low clear.
`timescale 1ns/1ps
module sipo_top
(
	input  wire logic                      clk_i,
	input  wire logic                      reset_n_i,
	input  wire logic                      serial_in_i,
	input  wire logic                      shift_clk_i,
	input  wire logic                      store_clk_i,
	input  wire logic                      shift_clear_n_i,
	input  wire logic                      store_clear_n_i,
	output logic                           serial_chain_out_o,
	output logic [sipo_pkg::SIPO_WIDTH-1:0] parallel_out_o
);
	import sipo_pkg::*;

	// synchronised pin levels
	logic [SIPO_SYNC_BITS-1:0] pins;
	logic                      data_s;
	logic                      shift_clk_s;
	logic                      store_clk_s;
	logic                      shift_clear_n_s;
	logic                      store_clear_n_s;

	// previous clock levels for edge detection
	logic shift_clk_prev;
	logic store_clk_prev;
	logic next_shift_clk_prev;
	logic next_store_clk_prev;
	logic shift_rise;
	logic store_rise;

	// the two registers of the block
	logic [SIPO_WIDTH-1:0] shift_stage_bits;
	logic [SIPO_WIDTH-1:0] next_shift_stage_bits;
	logic [SIPO_WIDTH-1:0] next_parallel_out;
	logic                  next_serial_chain_out;

	// rising edge of a sampled level against its previous sample
	function automatic logic rose(input logic now_level, input logic old_level);
		rose = now_level & ~old_level;
	endfunction

	// every pin crosses two flip-flops before anything reads it
	sipo_sync #(
		.WIDTH     (SIPO_SYNC_BITS),
		.RESET_VAL (SIPO_SYNC_RESET)
	) u_sync (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.async_i   ({store_clear_n_i, shift_clear_n_i, store_clk_i, shift_clk_i, serial_in_i}),
		.sync_o    (pins)
	);

	// unpack the bundle; serial data shares the clocks' delay so setup carries over
	always_comb begin
		data_s          = pins[SIPO_IDX_DATA];
		shift_clk_s     = pins[SIPO_IDX_SHCLK];
		store_clk_s     = pins[SIPO_IDX_STCLK];
		shift_clear_n_s = pins[SIPO_IDX_SHCLR];
		store_clear_n_s = pins[SIPO_IDX_STCLR];
	end

	// independent edge detectors, one per register clock
	always_comb begin
		next_shift_clk_prev = shift_clk_s;
		next_store_clk_prev = store_clk_s;
		shift_rise          = rose(shift_clk_s, shift_clk_prev);
		store_rise          = rose(store_clk_s, store_clk_prev);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			shift_clk_prev <= 1'b1;
			store_clk_prev <= 1'b1;
		end else begin
			shift_clk_prev <= next_shift_clk_prev;
			store_clk_prev <= next_store_clk_prev;
		end
	end

	// shift register: clear wins over any clock edge, as the pin is a level
	always_comb begin
		next_shift_stage_bits = shift_stage_bits;
		if (!shift_clear_n_s) begin
			next_shift_stage_bits = SIPO_REG_RESET;
		end else if (shift_rise) begin
			next_shift_stage_bits = {shift_stage_bits[SIPO_WIDTH-2:0], data_s};
		end
		// chain output is the top stage after the shift, i.e. the old stage 6
		next_serial_chain_out = next_shift_stage_bits[SIPO_WIDTH-1];
	end

	// storage register: reads the current shift contents, which are the
	// pre-shift values even when both clocks rise in the same cycle
	always_comb begin
		next_parallel_out = parallel_out_o;
		if (!store_clear_n_s) begin
			next_parallel_out = SIPO_REG_RESET;
		end else if (store_rise) begin
			if (!shift_clear_n_s) begin
				next_parallel_out = SIPO_REG_RESET;
			end else begin
				next_parallel_out = shift_stage_bits;
			end
		end
	end

	// outputs come straight from these flip-flops; chain out mirrors the top stage
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			shift_stage_bits   <= SIPO_REG_RESET;
			parallel_out_o     <= SIPO_REG_RESET;
			serial_chain_out_o <= 1'b0;
		end else begin
			shift_stage_bits   <= next_shift_stage_bits;
			parallel_out_o     <= next_parallel_out;
			serial_chain_out_o <= next_serial_chain_out;
		end
	end

	// ---- checks on the block's own behaviour ----

	// a shift edge with clear high moves every stage up and takes the data bit
	a_shift_moves_up: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(shift_rise && shift_clear_n_s) |=>
			shift_stage_bits == {$past(shift_stage_bits[SIPO_WIDTH-2:0]), $past(data_s)})
		else $error("shift register did not advance by one stage");

	// without a shift edge and with its clear high the shift register holds
	a_shift_holds_idle: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(!shift_rise && shift_clear_n_s) |=> $stable(shift_stage_bits))
		else $error("shift register changed without a shift edge");

	// chain output shows the former stage 6 after a shift
	a_chain_old_six: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(shift_rise && shift_clear_n_s) |=>
			serial_chain_out_o == $past(shift_stage_bits[SIPO_WIDTH-2]))
		else $error("chain output is not the former stage 6");

	// chain output always tracks the top stage
	a_chain_top_stage: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		serial_chain_out_o == shift_stage_bits[SIPO_WIDTH-1])
		else $error("chain output differs from the top stage");

	// shift clear held low keeps stages and chain output at zero
	a_shift_clear_zero: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(!shift_clear_n_s)[*2] |->
			(shift_stage_bits == SIPO_REG_RESET) && !serial_chain_out_o)
		else $error("shift clear did not hold the stages low");

	// shift clear alone leaves the storage register unchanged
	a_shift_clear_keeps_store: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(!shift_clear_n_s && store_clear_n_s && !store_rise) |=> $stable(parallel_out_o))
		else $error("shift clear disturbed the storage register");

	// storage clear held low keeps parallel outputs low
	a_store_clear_zero: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		!store_clear_n_s |=> (parallel_out_o == SIPO_REG_RESET))
		else $error("storage clear did not hold the outputs low");

	// storage clear does not touch the shift register
	a_store_clear_keeps_shift: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(!store_clear_n_s && shift_clear_n_s && !shift_rise) |=> $stable(shift_stage_bits))
		else $error("storage clear disturbed the shift register");

	// a store edge copies the pre-edge shift contents, even with a shift edge alongside
	a_store_copies_old: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(store_rise && store_clear_n_s && shift_clear_n_s) |=>
			parallel_out_o == $past(shift_stage_bits))
		else $error("storage register did not capture the shift contents");

	// both clocks together: storage lags the shift register by one shift
	a_both_clocks_lag: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(store_rise && shift_rise && store_clear_n_s && shift_clear_n_s) |=>
			shift_stage_bits[SIPO_WIDTH-1:1] == parallel_out_o[SIPO_WIDTH-2:0])
		else $error("storage register is not one shift behind");

	// store edge during shift clear loads zeros
	a_store_empty_load: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(store_rise && store_clear_n_s && !shift_clear_n_s) |=>
			parallel_out_o == SIPO_REG_RESET)
		else $error("store edge under shift clear did not load zeros");

	// a store pin rising reaches the internal store edge within the synchroniser latency
	a_store_pin_latency: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		($rose(store_clk_i) && store_clear_n_i && shift_clear_n_i)[*1] ##1
			(store_clear_n_i && shift_clear_n_i && store_clk_i)[*3] |->
			$past(store_rise, 1) || $past(store_rise, 2) || store_rise)
		else $error("store clock pin edge was not seen in time");

	// storage register never moves without a store edge or its clear
	a_store_holds_idle: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(store_clear_n_s && !store_rise) |=> $stable(parallel_out_o))
		else $error("storage register changed without a store edge");

	// ---- checks that tie the pin levels to the registers ----
	// pin timing here assumes each pin level lasts several clk_i periods

	// the shift pin rising reaches the internal edge within the synchroniser latency
	a_shift_pin_latency: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		($rose(shift_clk_i) && shift_clear_n_i) ##1
			(shift_clear_n_i && shift_clk_i)[*3] |->
			$past(shift_rise, 1) || $past(shift_rise, 2) || shift_rise)
		else $error("shift clock pin edge was not seen in time");

	// shift clear pin low for four samples leaves the stages and chain output empty
	a_shift_clear_pin: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(!shift_clear_n_i)[*4] |->
			(shift_stage_bits == SIPO_REG_RESET) && !serial_chain_out_o)
		else $error("shift clear pin did not empty the stages in time");

	// storage clear pin low for four samples leaves the outputs low
	a_store_clear_pin: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(!store_clear_n_i)[*4] |->
			(parallel_out_o == SIPO_REG_RESET))
		else $error("storage clear pin did not zero the outputs in time");

	// a store edge alone leaves the shift register as it was
	a_store_keeps_shift: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(store_rise && !shift_rise && shift_clear_n_s) |=> $stable(shift_stage_bits))
		else $error("store edge disturbed the shift register");

	// both clocks together: the chain output equals stored bit 6
	a_both_clocks_chain: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(store_rise && shift_rise && store_clear_n_s && shift_clear_n_s) |=>
			serial_chain_out_o == parallel_out_o[SIPO_WIDTH-2])
		else $error("chain output is not one shift ahead of the outputs");

	// first edge after reset release sees both registers empty
	a_reset_empties: assert property (
		@(posedge clk_i)
		$rose(reset_n_i) |->
			(shift_stage_bits == SIPO_REG_RESET) && (parallel_out_o == SIPO_REG_RESET)
			&& !serial_chain_out_o)
		else $error("registers were not empty on leaving reset");

	// a shift edge during shift clear is ignored: the clear wins
	a_shift_clear_wins: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(!shift_clear_n_s && shift_rise) |=>
			(shift_stage_bits == SIPO_REG_RESET) && !serial_chain_out_o)
		else $error("shift edge moved the stages during shift clear");

	// storage clear leaves the chain output alone
	a_store_clear_chain: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(!store_clear_n_s && shift_clear_n_s && !shift_rise) |=>
			$stable(serial_chain_out_o))
		else $error("storage clear disturbed the chain output");

	// an internal store edge only follows a real store pin rise, never the shift pin
	a_store_rise_pin: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		store_rise |-> $past(store_clk_i, 2) && !$past(store_clk_i, 3))
		else $error("store edge without a store clock pin rise");

	// an internal shift edge only follows a real shift pin rise, never the store pin
	a_shift_rise_pin: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		shift_rise |-> $past(shift_clk_i, 2) && !$past(shift_clk_i, 3))
		else $error("shift edge without a shift clock pin rise");

	// a store edge during storage clear still leaves the outputs low
	a_store_clear_wins: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(!store_clear_n_s && store_rise) |=>
			parallel_out_o == SIPO_REG_RESET)
		else $error("store edge loaded data during storage clear");

	// a plain store leaves the outputs equal to the unchanged shift register
	a_store_follows_shift: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(store_rise && !shift_rise && store_clear_n_s && shift_clear_n_s) |=>
			parallel_out_o == shift_stage_bits)
		else $error("outputs differ from the shift register after a store");

	// a shift edge alone leaves the storage register as it was
	a_shift_keeps_store: assert property (
		@(posedge clk_i) disable iff (!reset_n_i)
		(shift_rise && !store_rise && store_clear_n_s) |=> $stable(parallel_out_o))
		else $error("shift edge disturbed the storage register");
endmodule

// File: dv/sipo_host.sv
// sipo_host: behavioural controller that drives the pins of the shift/store block.
// assumes clk_i is the system clock; every pin change lands 1 ns after its rising edge.
`timescale 1ns/1ps
module sipo_host (
	input  wire logic clk_i,
	output logic      serial_in_o,
	output logic      shift_clk_o,
	output logic      store_clk_o,
	output logic      shift_clear_n_o,
	output logic      store_clear_n_o
);
	// each clock phase; longer than the three periods the synchroniser needs
	localparam int PH = 4;

	// idle pins: clocks low, clears released
	initial begin
		serial_in_o     = 1'b0;
		shift_clk_o     = 1'b0;
		store_clk_o     = 1'b0;
		shift_clear_n_o = 1'b1;
		store_clear_n_o = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// one pulse on either or both clocks; data settles a phase ahead and is then spoilt
	task automatic pulse(input logic sh, input logic st, input logic d);
		serial_in_o = d;
		tick(PH);
		shift_clk_o = sh;
		store_clk_o = st;
		tick(PH);
		shift_clk_o = 1'b0;
		store_clk_o = 1'b0;
		serial_in_o = ~d;
		tick(PH);
	endtask

	// first bit ends in the top stage; the store follows the eighth shift
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			pulse(1'b1, 1'b0, b[i]);
		end
		pulse(1'b0, 1'b1, 1'b0);
	endtask

	// clear levels, held long enough for the block to act on them
	task automatic set_clears(input logic sh, input logic st);
		shift_clear_n_o = sh;
		store_clear_n_o = st;
		tick(PH + 2);
	endtask
endmodule

// File: dv/test_sipo_top.sv
// test_sipo_top: self-checking bench for the shift/store block.
// assumes sipo_host drives the pins; the bench only resets and compares.
`timescale 1ns/1ps
module test_sipo_top;
	import sipo_pkg::*;
	logic                  clk_i;
	logic                  reset_n_i;
	logic                  serial_in;
	logic                  shift_clk;
	logic                  store_clk;
	logic                  shift_clear_n;
	logic                  store_clear_n;
	logic                  serial_chain_out;
	logic [SIPO_WIDTH-1:0] parallel_out;
	int                    n_mismatch = 0;
	int                    tests_run  = 0;
	// rows: byte shifted in, parallel word after the store, chain bit after the store
	logic [16:0] rows [5] = '{{8'ha5, 8'ha5, 1'b1}, {8'h01, 8'h01, 1'b0},
		{8'h80, 8'h80, 1'b1}, {8'hff, 8'hff, 1'b1}, {8'h5a, 8'h5a, 1'b0}};

	sipo_host host (.clk_i(clk_i), .serial_in_o(serial_in), .shift_clk_o(shift_clk),
		.store_clk_o(store_clk), .shift_clear_n_o(shift_clear_n),
		.store_clear_n_o(store_clear_n));

	sipo_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .serial_in_i(serial_in),
		.shift_clk_i(shift_clk), .store_clk_i(store_clk), .shift_clear_n_i(shift_clear_n),
		.store_clear_n_i(store_clear_n), .serial_chain_out_o(serial_chain_out),
		.parallel_out_o(parallel_out));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// the pins are driven by fixed counts, so a hang can only be a stuck run
	initial begin
		repeat (5000) @(posedge clk_i);
		n_mismatch++;
		end_of_test;
	end

	initial begin
		reset_n_i = 1'b0;
		repeat (3) @(posedge clk_i);
		#1 reset_n_i = 1'b1;
		check(parallel_out, 8'h00);
		check({7'h00, serial_chain_out}, 8'h00);
		foreach (rows[i]) begin
			host.send_byte(rows[i][16:9]);
			check(parallel_out, rows[i][8:1]);
			check({7'h00, serial_chain_out}, {7'h00, rows[i][0]});
		end
		// shift 5a -> b4: chain shows old stage 6, outputs keep the stored word
		host.pulse(1'b1, 1'b0, 1'b0);
		check({7'h00, serial_chain_out}, 8'h01);
		check(parallel_out, 8'h5a);
		// a second store proves the first left the shift register alone
		host.pulse(1'b0, 1'b1, 1'b0);
		host.pulse(1'b0, 1'b1, 1'b0);
		check(parallel_out, 8'hb4);
		// both clocks together: storage takes b4, shift becomes 68
		host.pulse(1'b1, 1'b1, 1'b0);
		check(parallel_out, 8'hb4);
		check({7'h00, serial_chain_out}, 8'h00);
		host.pulse(1'b0, 1'b1, 1'b0);
		check(parallel_out, 8'h68);
		// shift to d1, then hold the storage clear
		host.pulse(1'b1, 1'b0, 1'b1);
		host.set_clears(1'b1, 1'b0);
		check(parallel_out, 8'h00);
		check({7'h00, serial_chain_out}, 8'h01);
		host.pulse(1'b0, 1'b1, 1'b0);
		check(parallel_out, 8'h00);
		host.set_clears(1'b1, 1'b1);
		check(parallel_out, 8'h00);
		host.pulse(1'b0, 1'b1, 1'b0);
		check(parallel_out, 8'hd1);
		// shift clear: chain low, storage kept, shift clock ignored
		host.set_clears(1'b0, 1'b1);
		check({7'h00, serial_chain_out}, 8'h00);
		check(parallel_out, 8'hd1);
		host.pulse(1'b1, 1'b0, 1'b1);
		check({7'h00, serial_chain_out}, 8'h00);
		host.pulse(1'b0, 1'b1, 1'b0);
		check(parallel_out, 8'h00);
		host.set_clears(1'b1, 1'b1);
		host.send_byte(8'h3c);
		check(parallel_out, 8'h3c);
		// reset in mid-run empties both registers
		@(posedge clk_i);
		#1 reset_n_i = 1'b0;
		repeat (3) @(posedge clk_i);
		#1 reset_n_i = 1'b1;
		check(parallel_out, 8'h00);
		check({7'h00, serial_chain_out}, 8'h00);
		// first byte straight after the release: the block must take it whole
		host.send_byte(8'hc3);
		check(parallel_out, 8'hc3);
		check({7'h00, serial_chain_out}, 8'h01);
		end_of_test;
	end
endmodule
